/* File: tdr_defs.svh */
// Constants for the receive-side packet decode, route and traffic-class filter.
`ifndef TDR_DEFS_SVH
`define TDR_DEFS_SVH

// ****************************************************************
// Header field positions (first header dword, big-endian layout)
// ****************************************************************
`define TDR_FMT_HI 30
`define TDR_FMT_LO 29
`define TDR_TYPE_HI 28
`define TDR_TYPE_LO 24
`define TDR_TC_HI 22
`define TDR_TC_LO 20
`define TDR_LEN_HI 9
`define TDR_LEN_LO 0

// ****************************************************************
// Type field encodings
// ****************************************************************
`define TDR_TYPE_MEM 5'h00
`define TDR_TYPE_MEMLK 5'h01
`define TDR_TYPE_IO 5'h02
`define TDR_TYPE_CFG0 5'h04
`define TDR_TYPE_CFG1 5'h05
`define TDR_TYPE_CPL 5'h0a
`define TDR_TYPE_CPLLK 5'h0b
`define TDR_MSG_TOP 2'h2

// ****************************************************************
// Payload limits in dwords, and the isochronous enable position
// ****************************************************************
`define TDR_PAY_MIN_DW 7'h01
`define TDR_PAY_MAX_DW 7'h40
`define TDR_CFG_OFS 8'h40
`define TDR_VI_BIT 26
`define TDR_TC_ZERO 3'h0

// ****************************************************************
// Baseline message code groups
// ****************************************************************
`define TDR_MC_INTX_HI 4'h2
`define TDR_MC_PM 8'h14
`define TDR_MC_PM_TOP 5'h03
`define TDR_MC_ERR_TOP 6'h0c
`define TDR_MC_UNLOCK 8'h00
`define TDR_MC_SPL 8'h50
`define TDR_MC_VDM0 8'h7e
`define TDR_MC_VDM1 8'h7f
`define TDR_MC_HP_TOP 4'h4

`endif

/* File: tdr_pkg.sv */
// Types shared by the packet decode, route and traffic-class filter.
package tdr_pkg;

    // ****************************************************************
    // Route kinds and message groups
    // ****************************************************************
    typedef enum logic [1:0] {
        TDR_RT_ADDR = 2'b00,
        TDR_RT_ID = 2'b01,
        TDR_RT_IMPL = 2'b10,
        TDR_RT_NONE = 2'b11
    } tdr_route_e;

    typedef enum logic [2:0] {
        TDR_MG_NONE = 3'b000,
        TDR_MG_INTX = 3'b001,
        TDR_MG_PM = 3'b010,
        TDR_MG_ERR = 3'b011,
        TDR_MG_LOCK = 3'b100,
        TDR_MG_SPL = 3'b101,
        TDR_MG_VDM = 3'b110,
        TDR_MG_HP = 3'b111
    } tdr_msg_e;

    typedef enum logic [1:0] {
        TDR_ST_HDR = 2'b00,
        TDR_ST_REST = 2'b01,
        TDR_ST_DATA = 2'b10,
        TDR_ST_DROP = 2'b11
    } tdr_state_e;

    typedef logic [31:0] tdr_word_t;

endpackage

/* File: tdr_mem.sv */
// Small memory with registered read data, used as FIFO storage.
`timescale 1ns/100ps
module tdr_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic sys_clk, // System clock.
    input wire logic wrEn, // Write strobe.
    input wire logic [AW-1:0] wrAddr, // Write address.
    input wire logic [WIDTH-1:0] wrData, // Write data.
    input wire logic [AW-1:0] rdAddr, // Read address.
    output logic [WIDTH-1:0] rdData // Registered read data.
);
    logic [WIDTH-1:0] mem [DEPTH];

    // ****************************************************************
    // Storage
    // ****************************************************************
    // No reset on the array, so it maps onto plain memory cells.
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule // tdr_mem

/* File: tdr_fifo.sv */
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module tdr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk, // System clock.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic inValid, // Write side valid.
    output logic inReady, // Write side ready, low when full.
    input wire logic [WIDTH-1:0] inData, // Write data.
    output logic outValid, // Read side valid.
    input wire logic outReady, // Read side ready.
    output logic [WIDTH-1:0] outData // Read data.
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wrPtr;
        logic [AW:0] rdPtr;
        logic [AW:0] count;
        logic outValid;
    } tdr_fifo_s;

    tdr_fifo_s st_q;
    tdr_fifo_s st_d;
    logic doWr;
    logic doRd;
    logic [AW-1:0] rdAddr;
    logic [WIDTH-1:0] memData;

    // ****************************************************************
    // Pointer control
    // ****************************************************************
    // The output word is the registered memory read; one word is taken out of
    // the count as soon as it is fetched into the output stage.
    always_comb begin
        st_d = st_q;
        doWr = inValid && (st_q.count < (AW+1)'(DEPTH));
        doRd = (st_q.rdPtr != st_q.wrPtr) && (!st_q.outValid || outReady);
        rdAddr = st_q.rdPtr[AW-1:0];
        if (doWr) begin
            st_d.wrPtr = st_q.wrPtr + 1'b1;
        end
        if (doRd) begin
            st_d.rdPtr = st_q.rdPtr + 1'b1;
        end
        if (!st_q.outValid || outReady) begin
            st_d.outValid = doRd;
        end
        st_d.count = st_q.count + (AW+1)'(doWr) - (AW+1)'(doRd);
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    tdr_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
        .sys_clk(sys_clk),
        .wrEn(doWr),
        .wrAddr(st_q.wrPtr[AW-1:0]),
        .wrData(inData),
        .rdAddr(rdAddr),
        .rdData(memData)
    );

    // Read data is held in the output stage only while it is not taken.
    logic [WIDTH-1:0] hold_q;
    logic fresh_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_q <= '0;
            fresh_q <= 1'b0;
        end else begin
            fresh_q <= doRd;
            if (fresh_q) begin
                hold_q <= memData;
            end
        end
    end

    assign outData = fresh_q ? memData : hold_q;
    assign outValid = st_q.outValid;
    assign inReady = (st_q.count < (AW+1)'(DEPTH));
endmodule // tdr_fifo

/* File: tdr_filter.sv */
// Downstream packet decode, route selection and traffic-class filter.
// Overview of operation
// - Format field gives header length and data.
// - Payload must be one to sixty-four dwords.
// - Memory and I/O requests routed by address.
// - Configuration requests routed by bus/device/function.
// - Messages routed by three-bit routing subfield.
// - Baseline message groups recognised and classified.
// - Baseline messages must use traffic class zero.
// - Advanced switching messages are not supported.
// - Isochronous mode off at reset, set by bit.
// - Isochronous mode selects upstream class one-seven.
// - Config, I/O, message need class zero.
// - Memory packets forwarded whatever their class.
`timescale 1ns/100ps
`include "tdr_defs.svh"
module tdr_filter #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk, // System clock, 100 MHz.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic cfgWrEn, // Configuration dword write strobe.
    input wire logic [7:0] cfgWrOfs, // Configuration dword offset.
    input wire logic [31:0] cfgWrData, // Configuration write data.
    input wire logic [2:0] upTcSel, // Requested upstream traffic class.
    input wire logic rxValid, // Receive word valid.
    output logic rxReady, // Receive word accepted.
    input wire logic [31:0] rxData, // Receive word.
    input wire logic rxSop, // First header dword of a packet.
    input wire logic rxEop, // Last dword of a packet.
    output logic fwdValid, // Forward word valid.
    input wire logic fwdReady, // Forward side ready.
    output tdr_pkg::tdr_word_t fwdData, // Forward word.
    output logic pktValid, // One-cycle pulse with packet class.
    output tdr_pkg::tdr_route_e pktRoute, // Route kind of the packet.
    output logic [2:0] pktMsgRoute, // Message routing subfield.
    output tdr_pkg::tdr_msg_e pktMsgGroup, // Baseline message group.
    output logic pktHdr4, // Four-dword header.
    output logic pktHasData, // Packet carries data.
    output logic [6:0] pktLenDw, // Payload length in dwords.
    output logic pktMalformed, // Packet malformed; payload words after the fault are dropped.
    output logic pktUnsupported, // Packet dropped as unsupported.
    output logic viEnable, // Isochronous mode enabled.
    output logic [2:0] upTc // Traffic class used upstream.
);
    import tdr_pkg::*;

    typedef struct packed {
        tdr_state_e state;
        logic [2:0] hdrLeft;
        logic [6:0] dataLeft;
        logic viEn;
        logic [2:0] upTc;
        logic pktValid;
        tdr_route_e route;
        logic [2:0] msgRoute;
        tdr_msg_e msgGroup;
        logic hdr4;
        logic hasData;
        logic [6:0] lenDw;
        logic malformed;
        logic unsupported;
    } tdr_filter_s;

    tdr_filter_s st_q;
    tdr_filter_s st_d;
    logic fifoReady;
    logic fifoValid;
    tdr_word_t fifoData;
    logic pushValid;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // Length of zero encodes 1024 dwords, one above the largest value the field can hold.
    function automatic logic [10:0] len_dw(input logic [9:0] f);
        len_dw = (f == 10'h000) ? 11'h400 : {1'b0, f};
    endfunction

    function automatic tdr_msg_e msg_group(input logic [7:0] code);
        if (code[7:4] == `TDR_MC_INTX_HI && code[3:2] != 2'b11) begin
            msg_group = TDR_MG_INTX;
        end else if (code == `TDR_MC_PM || code[7:3] == `TDR_MC_PM_TOP) begin
            msg_group = TDR_MG_PM;
        end else if (code[7:2] == `TDR_MC_ERR_TOP) begin
            msg_group = TDR_MG_ERR;
        end else if (code == `TDR_MC_UNLOCK) begin
            msg_group = TDR_MG_LOCK;
        end else if (code == `TDR_MC_SPL) begin
            msg_group = TDR_MG_SPL;
        end else if (code == `TDR_MC_VDM0 || code == `TDR_MC_VDM1) begin
            msg_group = TDR_MG_VDM;
        end else if (code[7:4] == `TDR_MC_HP_TOP) begin
            msg_group = TDR_MG_HP;
        end else begin
            msg_group = TDR_MG_NONE;
        end
    endfunction

    // Header fields of the incoming first dword.
    logic [1:0] fmt;
    logic [4:0] ptype;
    logic [2:0] tc;
    logic [10:0] lenFull;
    logic take;
    assign fmt = rxData[`TDR_FMT_HI:`TDR_FMT_LO];
    assign ptype = rxData[`TDR_TYPE_HI:`TDR_TYPE_LO];
    assign tc = rxData[`TDR_TC_HI:`TDR_TC_LO];
    assign lenFull = len_dw(rxData[`TDR_LEN_HI:`TDR_LEN_LO]);
    // A word is consumed when it is valid and either the FIFO has room or it is
    // being dropped; dropping never waits on the forward side.
    assign take = rxValid && (fifoReady || st_q.state == TDR_ST_DROP);

    // ****************************************************************
    // Classification and forwarding control
    // ****************************************************************
    always_comb begin
        logic isMsg;
        logic isMem;
        logic isCfg;
        logic isIo;
        logic bad;
        logic unsup;
        logic [7:0] mcode;
        isMsg = 1'b0;
        isMem = 1'b0;
        isCfg = 1'b0;
        isIo = 1'b0;
        bad = 1'b0;
        unsup = 1'b0;
        mcode = 8'h00;
        st_d = st_q;
        st_d.pktValid = 1'b0;
        pushValid = 1'b0;
        // Isochronous enable lives at its configuration bit.
        if (cfgWrEn && cfgWrOfs == `TDR_CFG_OFS) begin
            st_d.viEn = cfgWrData[`TDR_VI_BIT];
        end
        // Upstream class follows the selection only with isochronous mode on.
        st_d.upTc = (st_d.viEn && upTcSel != `TDR_TC_ZERO) ? upTcSel : `TDR_TC_ZERO;
        case (st_q.state)
            TDR_ST_HDR: begin
                if (take && rxSop) begin
                    isMem = (ptype == `TDR_TYPE_MEM) || (ptype == `TDR_TYPE_MEMLK);
                    isIo = (ptype == `TDR_TYPE_IO);
                    isCfg = (ptype == `TDR_TYPE_CFG0) || (ptype == `TDR_TYPE_CFG1);
                    isMsg = (ptype[4:3] == `TDR_MSG_TOP);
                    st_d.hdr4 = fmt[0];
                    st_d.hasData = fmt[1];
                    st_d.lenDw = fmt[1] ? lenFull[6:0] : 7'h00;
                    // Payload above sixty-four dwords cannot be buffered.
                    if (fmt[1] && lenFull > 11'(`TDR_PAY_MAX_DW)) begin
                        bad = 1'b1;
                    end
                    if (isMem || isIo) begin
                        st_d.route = TDR_RT_ADDR;
                    end else if (isCfg) begin
                        st_d.route = TDR_RT_ID;
                    end else if (isMsg) begin
                        st_d.route = TDR_RT_IMPL;
                    end else begin
                        st_d.route = TDR_RT_NONE;
                    end
                    st_d.msgRoute = isMsg ? ptype[2:0] : 3'h0;
                    st_d.msgGroup = TDR_MG_NONE;
                    // Memory ignores class; configuration, I/O and message types must carry class zero.
                    if ((isCfg || isIo || isMsg) && tc != `TDR_TC_ZERO) begin
                        bad = 1'b1;
                    end
                    st_d.malformed = bad;
                    st_d.unsupported = 1'b0;
                    if (rxEop) begin
                        st_d.malformed = 1'b1;
                        st_d.pktValid = 1'b1;
                    end else begin
                        st_d.hdrLeft = fmt[0] ? 3'h3 : 3'h2;
                        st_d.dataLeft = st_d.lenDw;
                        st_d.state = TDR_ST_REST;
                    end
                end
            end
            TDR_ST_REST: begin
                if (take) begin
                    pushValid = 1'b0;
                    // Message code sits in the low byte of the second dword.
                    if (st_q.hdrLeft == (st_q.hdr4 ? 3'h3 : 3'h2) &&
                        st_q.route == TDR_RT_IMPL) begin
                        mcode = rxData[7:0];
                        st_d.msgGroup = msg_group(mcode);
                        unsup = (msg_group(mcode) == TDR_MG_NONE);
                        st_d.unsupported = unsup;
                    end
                    st_d.hdrLeft = st_q.hdrLeft - 3'h1;
                    if (st_q.hdrLeft == 3'h1) begin
                        if (rxEop || st_q.dataLeft == 7'h00) begin
                            st_d.pktValid = 1'b1;
                            st_d.malformed = st_q.malformed || !rxEop || st_q.hasData;
                            st_d.state = TDR_ST_HDR;
                        end else begin
                            st_d.state = TDR_ST_DATA;
                        end
                    end else if (rxEop) begin
                        st_d.pktValid = 1'b1;
                        st_d.malformed = 1'b1;
                        st_d.state = TDR_ST_HDR;
                    end
                end
            end
            TDR_ST_DATA: begin
                if (take) begin
                    // Good memory payload goes forward whatever its class.
                    pushValid = !st_q.malformed && !st_q.unsupported;
                    st_d.dataLeft = st_q.dataLeft - 7'h01;
                    if (rxEop) begin
                        st_d.malformed = st_q.malformed || (st_q.dataLeft != 7'h01);
                        st_d.pktValid = 1'b1;
                        st_d.state = TDR_ST_HDR;
                    end else if (st_q.dataLeft == 7'h01) begin
                        st_d.malformed = 1'b1;
                        st_d.state = TDR_ST_DROP;
                    end
                end
            end
            TDR_ST_DROP: begin
                if (take && rxEop) begin
                    st_d.pktValid = 1'b1;
                    st_d.state = TDR_ST_HDR;
                end
            end
            default: begin
                st_d.state = TDR_ST_HDR;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Payload buffer
    // ****************************************************************
    // Payload is buffered so the forward side can stall without losing words;
    // a full buffer pulls the receive ready low except while a packet is being dropped.
    tdr_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .inValid(pushValid),
        .inReady(fifoReady),
        .inData(rxData),
        .outValid(fifoValid),
        .outReady(fwdReady),
        .outData(fifoData)
    );

    assign rxReady = fifoReady || st_q.state == TDR_ST_DROP;
    assign fwdValid = fifoValid;
    assign fwdData = fifoData;
    assign pktValid = st_q.pktValid;
    assign pktRoute = st_q.route;
    assign pktMsgRoute = st_q.msgRoute;
    assign pktMsgGroup = st_q.msgGroup;
    assign pktHdr4 = st_q.hdr4;
    assign pktHasData = st_q.hasData;
    assign pktLenDw = st_q.lenDw;
    assign pktMalformed = st_q.malformed;
    assign pktUnsupported = st_q.unsupported;
    assign viEnable = st_q.viEn;
    assign upTc = st_q.upTc;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_vi_reset;
        @(posedge sys_clk) $fell(sys_rst) |-> !viEnable;
    endproperty
    a_vi_reset: assert property (p_vi_reset) else $error("iso mode on after reset");

    property p_uptc_off;
        @(posedge sys_clk) disable iff (sys_rst) !viEnable |-> upTc == 3'h0;
    endproperty
    a_uptc_off: assert property (p_uptc_off) else $error("upstream class while iso off");

    sequence s_cfg_tc_bad;
        st_q.state == TDR_ST_HDR && take && rxSop && tc != 3'h0 &&
            (ptype == 5'h04 || ptype == 5'h05 || ptype == 5'h02 || ptype[4:3] == 2'h2);
    endsequence
    property p_tc_bad;
        @(posedge sys_clk) disable iff (sys_rst) s_cfg_tc_bad ##1 1'b1 |-> st_q.malformed;
    endproperty
    a_tc_bad: assert property (p_tc_bad) else $error("class filter missed");

    property p_msg_route;
        @(posedge sys_clk) disable iff (sys_rst)
            st_q.state == TDR_ST_HDR && take && rxSop && ptype[4:3] == 2'h2 |=>
                pktRoute == TDR_RT_IMPL && pktMsgRoute == $past(ptype[2:0]);
    endproperty
    a_msg_route: assert property (p_msg_route) else $error("message route lost");

    property p_len_max;
        @(posedge sys_clk) disable iff (sys_rst) pktValid && !pktMalformed |-> pktLenDw <= 7'h40;
    endproperty
    a_len_max: assert property (p_len_max) else $error("payload over limit forwarded");

    property p_fmt;
        @(posedge sys_clk) disable iff (sys_rst)
            st_q.state == TDR_ST_HDR && take && rxSop |=>
                pktHdr4 == $past(fmt[0]) && pktHasData == $past(fmt[1]);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format decode wrong");

    property p_no_push_bad;
        @(posedge sys_clk) disable iff (sys_rst)
            pushValid |-> !st_q.malformed && st_q.state == TDR_ST_DATA;
    endproperty
    a_no_push_bad: assert property (p_no_push_bad) else $error("bad payload forwarded");

    property p_unsup;
        @(posedge sys_clk) disable iff (sys_rst) pktValid && pktUnsupported |-> pktMsgGroup == TDR_MG_NONE;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unsupported flag with known group");
endmodule // tdr_filter

/* File: tdr_sink_model.sv */
// Forward-side sink model that takes words promptly, slowly or not at all.
`timescale 1ns/100ps
module tdr_sink_model (
    input wire logic sys_clk, // System clock.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic fwdValid, // Word offered by the block.
    input wire logic hold, // Refuse every word while high.
    input wire logic slow, // Take a word only one cycle in three.
    output logic fwdReady // Word taken at the next edge.
);
    // ****************************************************************
    // Ready pattern
    // ****************************************************************
    logic [1:0] phaseQ;
    // Ready moves only on the edge, so a stalled word must stand until taken.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phaseQ <= 2'h0;
            fwdReady <= 1'b0;
        end else begin
            phaseQ <= (phaseQ == 2'h2) ? 2'h0 : phaseQ + 2'h1;
            fwdReady <= !hold && (!slow || phaseQ == 2'h2);
        end
    end
endmodule // tdr_sink_model

/* File: tb_tdr.sv */
// Self-checking testbench for the packet decode, route and class filter.
`timescale 1ns/100ps
module tb;
    import tdr_pkg::*;
    // ****************************************************************
    // Signals and bookkeeping
    // ****************************************************************
    logic sys_clk, sys_rst, cfgWrEn, rxValid, rxReady, rxSop, rxEop, fwdValid, fwdReady;
    logic pktValid, pktHdr4, pktHasData, pktMalformed, pktUnsupported, viEnable, hold, slow, r;
    logic [7:0] cfgWrOfs;
    logic [31:0] cfgWrData, rxData, seed;
    logic [2:0] upTcSel, pktMsgRoute, upTc;
    tdr_word_t fwdData;
    tdr_route_e pktRoute;
    tdr_msg_e pktMsgGroup;
    logic [6:0] pktLenDw;
    logic [18:0] expV[$], expM[$], ev, em;
    logic [31:0] fq[$];
    int nFail, numChecks, refusals;
    localparam logic [18:0] MD = 19'h607ff, MN = 19'h60603, MM = 19'h7fe03, MX = 19'h00003;
    localparam logic [7:0] CODES[7] = '{8'h20, 8'h14, 8'h30, 8'h00, 8'h50, 8'h7e, 8'h40};
    localparam tdr_msg_e GRPS[7] = '{TDR_MG_INTX, TDR_MG_PM, TDR_MG_ERR, TDR_MG_LOCK,
        TDR_MG_SPL, TDR_MG_VDM, TDR_MG_HP};

    tdr_filter tdr_filter_inst (.sys_clk, .sys_rst, .cfgWrEn, .cfgWrOfs, .cfgWrData,
        .upTcSel, .rxValid, .rxReady, .rxData, .rxSop, .rxEop, .fwdValid, .fwdReady,
        .fwdData, .pktValid, .pktRoute, .pktMsgRoute, .pktMsgGroup, .pktHdr4,
        .pktHasData, .pktLenDw, .pktMalformed, .pktUnsupported, .viEnable, .upTc);
    tdr_sink_model tdr_sink_model_inst (.sys_clk, .sys_rst, .fwdValid, .hold, .slow,
        .fwdReady);

    // Free-running system clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Compare one value and count it.
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (nFail == 0 && numChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cfgw(input logic [7:0] o, input logic [31:0] d);
        cfgWrEn = 1'b1;
        cfgWrOfs = o;
        cfgWrData = d;
        @(posedge sys_clk);
        #1 cfgWrEn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    // Sends a header of 3 or 4 dwords by format, then nd data dwords, and notes the class.
    task automatic pk(input logic [1:0] fm, input logic [4:0] ty, input logic [2:0] tc,
        input logic [9:0] ln, input logic [7:0] code, input int nd, input tdr_route_e rt,
        input tdr_msg_e mg, input logic mal, input logic uns, input logic [18:0] m);
        int nh;
        nh = fm[0] ? 4 : 3;
        expV.push_back({rt, ty[2:0], mg, fm[0], fm[1], ln[6:0], mal, uns});
        expM.push_back(m);
        for (int i = 0; i < nh + nd; i++) begin
            rxValid = 1'b1;
            rxSop = (i == 0);
            rxEop = (i == nh + nd - 1);
            rxData = (i == 0) ? {1'b0, fm, ty, 1'b0, tc, 10'h0, ln} : $random(seed);
            if (i == 1) rxData = {24'h0, code};
            // Payload behind a good header goes out up to its stated length.
            if (i >= nh && !uns && (!mal || (i - nh < ln && ln <= 64 && tc == 0))) begin
                fq.push_back(rxData);
            end
            do begin
                @(negedge sys_clk);
                r = rxReady;
                refusals += !r;
                @(posedge sys_clk);
            end while (!r);
            #1;
        end
        rxValid = 1'b0;
        rxSop = 1'b0;
        rxEop = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    // ****************************************************************
    // Output monitor and watchdog
    // ****************************************************************
    // Outputs are settled at the falling edge; a handshake there completes on the next rise.
    always @(negedge sys_clk) begin
        if (!sys_rst && pktValid === 1'b1) begin
            ev = expV.size() ? expV.pop_front() : 19'h7ffff;
            em = expM.size() ? expM.pop_front() : 19'h7ffff;
            check("pkt class", 32'({pktRoute, pktMsgRoute, pktMsgGroup, pktHdr4, pktHasData,
                pktLenDw, pktMalformed, pktUnsupported} & em), 32'(ev & em));
        end
        if (!sys_rst && fwdValid === 1'b1 && fwdReady === 1'b1) begin
            if (fq.size()) check("fwd data", fwdData, fq.pop_front());
            else check("fwd extra", 1'b1, 1'b0);
        end
    end

    initial begin
        #400000;
        nFail++;
        complete_run();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        seed = 32'hd6cd;
        {nFail, numChecks, refusals} = '0;
        {cfgWrEn, rxValid, rxSop, rxEop, hold, slow} = '0;
        {cfgWrOfs, cfgWrData, rxData} = '0;
        upTcSel = 3'h5;
        sys_rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        check("vi reset", viEnable, 1'b0);
        cfgw(8'h44, 32'h0400_0000);
        check("vi wrong ofs", viEnable, 1'b0);
        check("uptc off", upTc, 3'h0);
        cfgw(8'h40, 32'h0400_0000);
        check("vi on", viEnable, 1'b1);
        check("uptc on", upTc, 3'h5);
        pk(2'b10, 5'h00, 3'h0, 10'd1, 8'h0, 1, TDR_RT_ADDR, TDR_MG_NONE, 0, 0, MD);
        pk(2'b00, 5'h00, 3'h0, 10'd1, 8'h0, 0, TDR_RT_ADDR, TDR_MG_NONE, 0, 0, MN);
        pk(2'b01, 5'h00, 3'h0, 10'd1, 8'h0, 0, TDR_RT_ADDR, TDR_MG_NONE, 0, 0, MN);
        hold = 1'b1;
        fork
            pk(2'b11, 5'h00, 3'h5, 10'd64, 8'h0, 64, TDR_RT_ADDR, TDR_MG_NONE, 0, 0, MD);
            begin
                repeat (60) @(posedge sys_clk);
                #1 hold = 1'b0;
            end
        join
        check("fifo refused", refusals > 0, 1'b1);
        pk(2'b10, 5'h00, 3'h0, 10'd65, 8'h0, 65, TDR_RT_ADDR, TDR_MG_NONE, 1, 0, MX);
        pk(2'b10, 5'h00, 3'h0, 10'd4, 8'h0, 2, TDR_RT_ADDR, TDR_MG_NONE, 1, 0, MX);
        pk(2'b10, 5'h00, 3'h0, 10'd0, 8'h0, 1, TDR_RT_ADDR, TDR_MG_NONE, 1, 0, MX);
        pk(2'b10, 5'h00, 3'h0, 10'd1, 8'h0, 2, TDR_RT_ADDR, TDR_MG_NONE, 1, 0, MX);
        pk(2'b10, 5'h02, 3'h0, 10'd1, 8'h0, 1, TDR_RT_ADDR, TDR_MG_NONE, 0, 0, MD);
        pk(2'b10, 5'h02, 3'h3, 10'd1, 8'h0, 1, TDR_RT_ADDR, TDR_MG_NONE, 1, 0, MX);
        pk(2'b00, 5'h04, 3'h0, 10'd1, 8'h0, 0, TDR_RT_ID, TDR_MG_NONE, 0, 0, MN);
        pk(2'b00, 5'h05, 3'h1, 10'd1, 8'h0, 0, TDR_RT_ID, TDR_MG_NONE, 1, 0, MX);
        for (int i = 0; i < 7; i++) begin
            pk(2'b01, {2'h2, 3'(i % 6)}, 3'h0, 10'd1, CODES[i], 0, TDR_RT_IMPL, GRPS[i], 0, 0,
                MM);
        end
        pk(2'b01, 5'h14, 3'h1, 10'd1, 8'h14, 0, TDR_RT_IMPL, TDR_MG_PM, 1, 0, MX);
        pk(2'b01, 5'h10, 3'h0, 10'd1, 8'h60, 0, TDR_RT_IMPL, TDR_MG_NONE, 0, 1, MX);
        slow = 1'b1;
        for (int i = 0; i < 8; i++) begin
            upTcSel = 3'($random(seed));
            pk(2'b10, 5'h00, 3'($random(seed)), 10'(i + 1), 8'h0, i + 1, TDR_RT_ADDR,
                TDR_MG_NONE, 0, 0, MD);
            check("uptc sel", upTc, upTcSel);
        end
        repeat (300) @(posedge sys_clk);
        check("drained", fwdValid, 1'b0);
        check("pkt left", expV.size() + fq.size(), 0);
        complete_run();
    end
endmodule // tb
